// ---- design/ccr_cmp_chan.v ----
// One comparator channel: input sync, Timer1 latch, polarity, mismatch detection.
`timescale 1ns/1ps
`include "ccr_map.vh"
module ccr_cmp_chan
(
  input wire ref_clk,
  input wire rst_b,
  input wire raw_out,
  input wire enable,
  input wire invert,
  input wire sync_mode,
  input wire timer1_source_clock,
  input wire access_strobe,
  output wire result,
  output reg mismatch_pulse
);
  // ==========================================================
  // Synchronisers
  // Analog output and Timer1 clock are asynchronous; three stages each.
  reg [2:0] cmp_sync_q;
  reg [2:0] tclk_sync_q;
  reg cmp_stable_q;
  reg tclk_stable_q;
  reg tclk_prev_q;
  reg latched_q;
  reg first_latch_q;
  reg second_latch_q;
  reg mism_prev_q;
  wire raw_res;
  wire sel_res;
  wire mism;
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cmp_sync_q <= 3'h0;
      tclk_sync_q <= 3'h0;
      cmp_stable_q <= 1'b0;
      tclk_stable_q <= 1'b0;
    end
    else
    begin
      cmp_sync_q <= {cmp_sync_q[1:0], raw_out};
      tclk_sync_q <= {tclk_sync_q[1:0], timer1_source_clock};
      if (cmp_sync_q[1] == cmp_sync_q[2])
        cmp_stable_q <= cmp_sync_q[2];
      if (tclk_sync_q[1] == tclk_sync_q[2])
        tclk_stable_q <= tclk_sync_q[2];
    end
  end
  // ==========================================================
  // Timer1 falling-edge latch
  // Capture on the falling edge keeps clear of the rising edge on which Timer1 counts.
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      tclk_prev_q <= 1'b0;
      latched_q <= 1'b0;
    end
    else
    begin
      tclk_prev_q <= tclk_stable_q;
      if (tclk_prev_q && !tclk_stable_q)
        latched_q <= cmp_stable_q;
    end
  end
  assign raw_res = sync_mode ? latched_q : cmp_stable_q;
  assign sel_res = enable ? raw_res : 1'b0;
  assign result = sel_res ^ invert;
  // ==========================================================
  // Mismatch latches
  assign mism = first_latch_q ^ second_latch_q;
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      first_latch_q <= 1'b0;
      second_latch_q <= 1'b0;
      mism_prev_q <= 1'b0;
      mismatch_pulse <= 1'b0;
    end
    else
    begin
      second_latch_q <= result;
      if (access_strobe)
        first_latch_q <= result;
      mism_prev_q <= mism;
      mismatch_pulse <= mism && !mism_prev_q;
    end
  end
endmodule // ccr_cmp_chan

// ---- design/ccr_map.vh ----
// Register map, field positions and reset values of the comparator control block.
//
// Behaviour
// - Enable bit 7 of each control register switches its comparator on or off.
// - Result bit 6 is one when the non-inverting input is higher, reversed if inverted.
// - Polarity bit 4 set inverts the result before the result bit and pin.
// - Pin is driven only with pin enable, comparator enable and port direction output.
// - Speed/power bit 3 resets to one; zero selects low power, low speed.
// - Reference route bit 2 picks internal reference output, else external pin.
// - Two-bit channel field selects one of four inverting-input pins.
// - Shared bits 5 and 4 pick fixed reference when set, DAC when clear.
// - Shared bits 3 and 2 enable hysteresis of comparator one and two.
// - Shared bits 7 and 6 mirror both comparator results for a single read.
// - Sync bit set latches the output on the Timer1 clock falling edge.
// - Timer1 counts on rising edge so falling-edge capture cannot race gating.
// - Interrupt flag sets when output differs from value latched at control access.
// - Reading mirror bits in the shared register leaves mismatch latches alone.
// - A disabled comparator's result takes the level of its polarity bit.
`ifndef CCR_MAP_VH
`define CCR_MAP_VH
// ==========================================================
// Register offsets
`define CCR_OFF_CTRL1 12'h000
`define CCR_OFF_CTRL2 12'h004
`define CCR_OFF_SHARED 12'h008
`define CCR_OFF_IRQ_STATUS 12'h00C
`define CCR_OFF_IRQ_MASK 12'h010
// ==========================================================
// Control register fields
`define CCR_CTL_EN 7
`define CCR_CTL_RES 6
`define CCR_CTL_OE 5
`define CCR_CTL_POL 4
`define CCR_CTL_SP 3
`define CCR_CTL_REF 2
`define CCR_CTL_CH_HI 1
`define CCR_CTL_CH_LO 0
`define CCR_CTL_RESET 8'h08
`define CCR_CTL_WMASK 8'hBF
// ==========================================================
// Shared register fields
`define CCR_SH_MIR1 7
`define CCR_SH_MIR2 6
`define CCR_SH_RSEL1 5
`define CCR_SH_RSEL2 4
`define CCR_SH_HYS1 3
`define CCR_SH_HYS2 2
`define CCR_SH_SYNC1 1
`define CCR_SH_SYNC2 0
`define CCR_SH_RESET 8'h00
`define CCR_SH_WMASK 8'h3F
`define CCR_IRQ_RESET 2'h0
`endif

// ---- design/ccr_top.v ----
// APB register block controlling two analog comparators.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ccr_map.vh"
module ccr_top
(
  input wire ref_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire cmp1_raw_out,
  input wire cmp2_raw_out,
  input wire timer1_source_clock,
  input wire port_direction_bit1,
  input wire port_direction_bit2,
  output wire cmp1_enable,
  output wire cmp2_enable,
  output wire cmp1_speed_power_select,
  output wire cmp2_speed_power_select,
  output wire cmp1_reference_route,
  output wire cmp2_reference_route,
  output wire [1:0] cmp1_channel_select,
  output wire [1:0] cmp2_channel_select,
  output wire cmp1_reference_source,
  output wire cmp2_reference_source,
  output wire cmp1_hysteresis_enable,
  output wire cmp2_hysteresis_enable,
  output reg cmp1_pin_out,
  output reg cmp1_pin_oe,
  output reg cmp2_pin_out,
  output reg cmp2_pin_oe,
  output wire irq
);
  // ==========================================================
  // Registers
  reg [7:0] ctrl1_q;
  reg [7:0] ctrl2_q;
  reg [7:0] shared_q;
  reg [1:0] irq_status_q;
  reg [1:0] irq_mask_q;
  wire res1;
  wire res2;
  wire mis1;
  wire mis2;
  wire access;
  wire wr;
  wire acc_ctrl1;
  wire acc_ctrl2;
  wire mapped;
  wire [1:0] clr;
  assign pready = 1'b1;
  assign access = psel && penable;
  assign wr = access && pwrite;
  // Reads and writes of a control register both reload its first mismatch latch.
  assign acc_ctrl1 = access && (paddr == `CCR_OFF_CTRL1);
  assign acc_ctrl2 = access && (paddr == `CCR_OFF_CTRL2);
  assign mapped = (paddr == `CCR_OFF_CTRL1) || (paddr == `CCR_OFF_CTRL2) ||
    (paddr == `CCR_OFF_SHARED) || (paddr == `CCR_OFF_IRQ_STATUS) ||
    (paddr == `CCR_OFF_IRQ_MASK);
  assign pslverr = access && !mapped;
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      ctrl1_q <= `CCR_CTL_RESET;
      ctrl2_q <= `CCR_CTL_RESET;
      shared_q <= `CCR_SH_RESET;
      irq_mask_q <= `CCR_IRQ_RESET;
    end
    else if (wr)
    begin
      if (paddr == `CCR_OFF_CTRL1)
        ctrl1_q <= pwdata[7:0] & `CCR_CTL_WMASK;
      if (paddr == `CCR_OFF_CTRL2)
        ctrl2_q <= pwdata[7:0] & `CCR_CTL_WMASK;
      if (paddr == `CCR_OFF_SHARED)
        shared_q <= pwdata[7:0] & `CCR_SH_WMASK;
      if (paddr == `CCR_OFF_IRQ_MASK)
        irq_mask_q <= pwdata[1:0];
    end
  end
  // ==========================================================
  // Interrupt status: set wins over write-one-to-clear.
  assign clr = (wr && (paddr == `CCR_OFF_IRQ_STATUS)) ? pwdata[1:0] : 2'h0;
  always @(posedge ref_clk)
  begin
    if (!rst_b)
      irq_status_q <= `CCR_IRQ_RESET;
    else
      irq_status_q <= (irq_status_q & ~clr) | {mis2, mis1};
  end
  assign irq = |(irq_status_q & irq_mask_q);
  // ==========================================================
  // Read path
  always @(posedge ref_clk)
  begin
    if (!rst_b)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0;
      case (paddr)
        `CCR_OFF_CTRL1: prdata[7:0] <= {ctrl1_q[7], res1, ctrl1_q[5:0]};
        `CCR_OFF_CTRL2: prdata[7:0] <= {ctrl2_q[7], res2, ctrl2_q[5:0]};
        // Mirror read does not touch the mismatch latches.
        `CCR_OFF_SHARED: prdata[7:0] <= {res1, res2, shared_q[5:0]};
        `CCR_OFF_IRQ_STATUS: prdata[1:0] <= irq_status_q;
        `CCR_OFF_IRQ_MASK: prdata[1:0] <= irq_mask_q;
        default: prdata <= 32'h0;
      endcase
    end
  end
  // ==========================================================
  // Analog control outputs
  assign cmp1_enable = ctrl1_q[`CCR_CTL_EN];
  assign cmp2_enable = ctrl2_q[`CCR_CTL_EN];
  assign cmp1_speed_power_select = ctrl1_q[`CCR_CTL_SP];
  assign cmp2_speed_power_select = ctrl2_q[`CCR_CTL_SP];
  assign cmp1_reference_route = ctrl1_q[`CCR_CTL_REF];
  assign cmp2_reference_route = ctrl2_q[`CCR_CTL_REF];
  assign cmp1_channel_select = ctrl1_q[`CCR_CTL_CH_HI:`CCR_CTL_CH_LO];
  assign cmp2_channel_select = ctrl2_q[`CCR_CTL_CH_HI:`CCR_CTL_CH_LO];
  assign cmp1_reference_source = shared_q[`CCR_SH_RSEL1];
  assign cmp2_reference_source = shared_q[`CCR_SH_RSEL2];
  assign cmp1_hysteresis_enable = shared_q[`CCR_SH_HYS1];
  assign cmp2_hysteresis_enable = shared_q[`CCR_SH_HYS2];
  // ==========================================================
  // Pins: port direction bit low means output.
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cmp1_pin_out <= 1'b0;
      cmp1_pin_oe <= 1'b0;
      cmp2_pin_out <= 1'b0;
      cmp2_pin_oe <= 1'b0;
    end
    else
    begin
      cmp1_pin_out <= res1;
      cmp2_pin_out <= res2;
      cmp1_pin_oe <= ctrl1_q[`CCR_CTL_OE] && ctrl1_q[`CCR_CTL_EN] && !port_direction_bit1;
      cmp2_pin_oe <= ctrl2_q[`CCR_CTL_OE] && ctrl2_q[`CCR_CTL_EN] && !port_direction_bit2;
    end
  end
  // ==========================================================
  // Channels
  ccr_cmp_chan u_chan1
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raw_out(cmp1_raw_out),
    .enable(ctrl1_q[`CCR_CTL_EN]),
    .invert(ctrl1_q[`CCR_CTL_POL]),
    .sync_mode(shared_q[`CCR_SH_SYNC1]),
    .timer1_source_clock(timer1_source_clock),
    .access_strobe(acc_ctrl1),
    .result(res1),
    .mismatch_pulse(mis1)
  );
  ccr_cmp_chan u_chan2
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raw_out(cmp2_raw_out),
    .enable(ctrl2_q[`CCR_CTL_EN]),
    .invert(ctrl2_q[`CCR_CTL_POL]),
    .sync_mode(shared_q[`CCR_SH_SYNC2]),
    .timer1_source_clock(timer1_source_clock),
    .access_strobe(acc_ctrl2),
    .result(res2),
    .mismatch_pulse(mis2)
  );
endmodule // ccr_top

// ---- sim/ccr_analog_model.sv ----
// Behavioural analog comparators and Timer1 clock source.
`timescale 1ns/1ps
module ccr_analog_model
(
  input wire logic [1:0] vin_gt,
  input wire logic t1_run,
  output wire logic cmp1_raw_out,
  output wire logic cmp2_raw_out,
  output logic timer1_source_clock
);
  // ==========================================================
  // Far side.
  logic [7:0] t1_count = 8'h00;
  // Outputs move a few ns after the inputs, never on a clock edge.
  assign #7 {cmp1_raw_out, cmp2_raw_out} = vin_gt;
  // Timer clock stands low between runs and has its own phase.
  initial timer1_source_clock = 1'b0;
  always #130 timer1_source_clock = t1_run & ~timer1_source_clock;
  always @(posedge timer1_source_clock) t1_count <= t1_count + 8'h01;
endmodule // ccr_analog_model

// ---- sim/ccr_checker.sv ----
// Concurrent checks on the comparator control block ports.
`timescale 1ns/1ps
module ccr_checker
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic port_direction_bit1,
  input wire logic cmp1_enable,
  input wire logic cmp2_enable,
  input wire logic cmp1_speed_power_select,
  input wire logic [1:0] cmp2_channel_select,
  input wire logic cmp1_reference_source,
  input wire logic cmp2_hysteresis_enable,
  input wire logic cmp1_pin_oe,
  input wire logic cmp2_pin_oe,
  input wire logic irq
);
  // ==========================================================
  // Properties.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire mapped_addr = (paddr == 12'h000) || (paddr == 12'h004) || (paddr == 12'h008) ||
    (paddr == 12'h00C) || (paddr == 12'h010);
  AST_SLVERR: assert property (acc |-> pslverr == !mapped_addr) else $error("bad slverr");
  AST_ENABLE: assert property (wr && paddr == 12'h000 |=> cmp1_enable == $past(pwdata[7]))
    else $error("enable");
  AST_CHANNEL: assert property (wr && paddr == 12'h004 |=>
    cmp2_channel_select == $past(pwdata[1:0])) else $error("channel");
  AST_SHARED: assert property (wr && paddr == 12'h008 |=>
    {cmp1_reference_source, cmp2_hysteresis_enable} == {$past(pwdata[5]), $past(pwdata[2])})
    else $error("shared");
  AST_SPEED_RST: assert property ($rose(rst_b) |-> cmp1_speed_power_select)
    else $error("speed");
  AST_PIN_OE: assert property (cmp1_pin_oe |->
    $past(cmp1_enable) && !$past(port_direction_bit1)) else $error("pin oe");
  AST_PIN_OFF: assert property (!cmp2_enable [*2] |-> !cmp2_pin_oe)
    else $error("pin off");
  AST_MASK: assert property (wr && paddr == 12'h010 && pwdata[1:0] == 2'h0 |=> !irq)
    else $error("mask");
  cover property (wr && paddr == 12'h000);
  cover property ($rose(irq));
  cover property (acc && pslverr);
endmodule // ccr_checker

bind ccr_top ccr_checker u_chk (.*);

// ---- sim/ccr_tb_top.sv ----
// Self-checking bench for the comparator control block.
`timescale 1ns/1ps
module ccr_tb_top;
  logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic port_direction_bit1 = 1'b1, port_direction_bit2 = 1'b1, t1_run = 1'b0;
  logic [1:0] vin_gt = 2'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd;
  wire [31:0] prdata;
  wire [1:0] cmp1_channel_select, cmp2_channel_select;
  wire pready, pslverr, cmp1_raw_out, cmp2_raw_out, timer1_source_clock, irq, cmp1_enable;
  wire cmp2_enable, cmp1_speed_power_select, cmp2_speed_power_select, cmp1_reference_route;
  wire cmp2_reference_route, cmp1_reference_source, cmp2_reference_source, cmp1_pin_out;
  wire cmp1_hysteresis_enable, cmp2_hysteresis_enable, cmp1_pin_oe, cmp2_pin_out, cmp2_pin_oe;
  int error_cnt = 0, comparisons = 0;
  ccr_top uut (.*);
  ccr_analog_model u_analog (.*);
  always #25 ref_clk = ~ref_clk;
  // ==========================================================
  // Shared tasks.
  task automatic complete_run;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] exp, input logic [32:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
    begin
      error_cnt++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // Result path is about five cycles and the flag two more, so ten covers both.
  task automatic settle;
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic drive(input logic [1:0] v, input logic dir);
    @(posedge ref_clk);
    vin_gt <= v;
    port_direction_bit1 <= dir;
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_ctrl;
    bus(1'b0, 12'h004, 8'h00);
    chk(32'h08, rd);
    drive(2'b10, 1'b0);
    bus(1'b1, 12'h000, 8'hEF);
    settle();
    bus(1'b0, 12'h000, 8'h00);
    chk(32'hEF, rd);
    chk(5'h1F, {cmp1_enable, cmp1_reference_route, cmp1_channel_select, cmp1_pin_oe});
    chk(2'h3, {cmp1_pin_out, cmp1_speed_power_select});
    drive(2'b10, 1'b1);
    bus(1'b1, 12'h000, 8'hBF);
    settle();
    chk(1'b0, cmp1_pin_oe);
    bus(1'b0, 12'h000, 8'h00);
    chk(32'hBF, rd);
    bus(1'b1, 12'h000, 8'h10);
    settle();
    bus(1'b0, 12'h000, 8'h00);
    chk(32'h50, rd);
    chk(2'h0, {cmp1_enable, cmp1_speed_power_select});
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 12'h004, 8'(i));
      chk(i, cmp2_channel_select);
    end
    chk(3'h0, {cmp2_enable, cmp2_speed_power_select, cmp2_reference_route});
    bus(1'b1, 12'h008, 8'hFC);
    bus(1'b0, 12'h008, 8'h00);
    chk(32'hBC, rd);
    chk(2'h3, {cmp1_reference_source, cmp2_reference_source});
    chk(2'h3, {cmp1_hysteresis_enable, cmp2_hysteresis_enable});
    bus(1'b1, 12'h014, 8'hFF);
    bus(1'b0, 12'h014, 8'h00);
    chk(33'h100000000, {err, rd});
  endtask
  task automatic t_sync;
    drive(2'b00, 1'b1);
    bus(1'b1, 12'h004, 8'h80);
    bus(1'b1, 12'h008, 8'h01);
    drive(2'b01, 1'b1);
    settle();
    bus(1'b0, 12'h008, 8'h00);
    chk(32'h81, rd);
    @(posedge ref_clk);
    t1_run <= 1'b1;
    settle();
    settle();
    bus(1'b0, 12'h008, 8'h00);
    chk(32'hC1, rd);
    chk(2'h2, {cmp2_pin_out, cmp2_pin_oe});
    t1_run <= 1'b0;
  endtask
  task automatic t_irq;
    bus(1'b1, 12'h008, 8'h00);
    bus(1'b1, 12'h010, 8'h03);
    settle();
    bus(1'b0, 12'h004, 8'h00);
    bus(1'b1, 12'h00C, 8'h03);
    chk(1'b0, irq);
    drive(2'b00, 1'b1);
    for (int n = 0; n < 20 && irq !== 1'b1; n++)
      @(posedge ref_clk);
    chk(1'b1, irq);
    bus(1'b0, 12'h00C, 8'h00);
    chk(32'h02, rd);
    bus(1'b0, 12'h008, 8'h00);
    bus(1'b1, 12'h00C, 8'h02);
    drive(2'b01, 1'b1);
    settle();
    bus(1'b0, 12'h00C, 8'h00);
    chk(32'h00, rd);
    bus(1'b1, 12'h010, 8'h00);
    drive(2'b00, 1'b1);
    settle();
    chk(1'b0, irq);
    bus(1'b0, 12'h00C, 8'h00);
    chk(32'h02, rd);
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_ctrl();
    t_regs();
    t_sync();
    t_irq();
    complete_run();
  end
endmodule // ccr_tb_top
